// ==== hw/pcu_defs.svh ====
// pcu_defs.svh: offsets, field positions, reset values, timing figures
// assumes inclusion by bare name from the pen control unit sources
`ifndef PCU_DEFS_SVH
`define PCU_DEFS_SVH
`define PCU_A_PARAM0 8'h00
`define PCU_A_PARAM1 8'h04
`define PCU_A_CMD 8'h08
`define PCU_A_CTRL 8'h0c
`define PCU_A_ERR 8'h10
`define PCU_A_FORCES 8'h14
`define PCU_A_STATUS 8'h18
`define PCU_A_DEFAULTS 8'h1c
`define PCU_B_LIFT 0
`define PCU_B_STOW 1
`define PCU_B_DEFER 2
`define PCU_B_MERGE 3
`define PCU_CTRL_RST 4'h7
`define PCU_AUTO_MAX 16'sh000f
`define PCU_PEN_MAX 16'sh0008
`define PCU_FORCE_MAX 4'h8
`define PCU_FORCE_DRAFT 4'h1
`define PCU_FORCE_FIBER 4'h2
`define PCU_FORCE_ROLLER 4'h6
`define PCU_ERR_NONE 2'h0
`define PCU_ERR_COUNT 2'h2
`define PCU_ERR_RANGE 2'h3
`define PCU_G1 7'h0f
`define PCU_G2 7'h18
`define PCU_G3 7'h1e
`define PCU_G4 7'h24
`define PCU_G5 7'h2d
`define PCU_G6 7'h33
`define PCU_G7 7'h39
`define PCU_G8 7'h42
`define PCU_CLK_HZ 20000000
`define PCU_IDLE_LONG_S 65
`define PCU_IDLE_SHORT_S 15
`endif

// ==== hw/pcu_pkg.sv ====
// pcu_pkg: types of the pen control command unit
// assumes nothing from pcu_defs.svh: the enum encodings are written out here
package pcu_pkg;
  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_AUTO = 2'h1,
    OP_FORCE = 2'h2,
    OP_CHOOSE = 2'h3
  } pcu_op_e;
  typedef enum logic [2:0] {
    CAR_NONE = 3'h0,
    CAR_PAPER = 3'h1,
    CAR_ROLLER = 3'h2,
    CAR_TRANSP = 3'h3,
    CAR_DRAFT = 3'h4
  } pcu_car_e;
  typedef enum logic [2:0] {
    IDLE_OFF = 3'b001,
    IDLE_RUN = 3'b010,
    IDLE_DONE = 3'b100
  } pcu_idle_e;
  typedef struct packed {
    logic moving;
    logic down;
    logic in_holder;
    logic manual;
    logic fetch_done;
    logic stow_fail;
    logic draw_need;
    logic fp_sel;
    logic fp_force;
    logic [3:0] value;
    logic [2:0] car;
  } pcu_pins_s;
  typedef struct packed {
    logic [2:0] cnt;
    pcu_op_e op;
  } pcu_cmd_s;
endpackage

// ==== hw/pcu_top.sv ====
// pcu_top: pen automation and pen force command unit
// assumes a host writing params then a command word over the plain port,
// and mechanism pins that are asynchronous to CLK
`timescale 1ns/1ps
`include "pcu_defs.svh"

module pcu_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

module pcu_top #(
  parameter logic [31:0] IDLE_LONG_CYC = 32'(`PCU_IDLE_LONG_S * `PCU_CLK_HZ),
  parameter logic [31:0] IDLE_SHORT_CYC = 32'(`PCU_IDLE_SHORT_S * `PCU_CLK_HZ)
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic PEN_MOVING,
  input wire logic PEN_DOWN,
  input wire logic PEN_IN_HOLDER,
  input wire logic PEN_MANUAL,
  input wire logic FETCH_DONE,
  input wire logic STOW_FAIL,
  input wire logic DRAW_NEED,
  input wire logic FP_SEL,
  input wire logic FP_FORCE,
  input wire logic [3:0] FP_VALUE,
  input wire pcu_pkg::pcu_car_e CAROUSEL,
  output logic LIFT_REQ,
  output logic STOW_REQ,
  output logic FETCH_REQ,
  output logic [3:0] FETCH_PEN,
  output logic MERGE_EN,
  output logic [3:0] FORCE_CODE,
  output logic [6:0] FORCE_GRAMS
);
  import pcu_pkg::*;

  pcu_pins_s raw;
  pcu_pins_s pins;
  pcu_pins_s prev_q;
  pcu_cmd_s cmd;
  logic [15:0] param0_q;
  logic [15:0] param1_q;
  logic [3:0] ctrl_q;
  logic [1:0] err_q;
  logic [3:0] force_q [0:7];
  pcu_car_e car_q;
  logic pend_q;
  logic [3:0] pend_pen_q;
  logic [3:0] cur_pen_q;
  logic known_q;
  pcu_idle_e st_q;
  logic [31:0] cnt_q;
  logic fire_q;
  logic [31:0] rdata_d;

  assign raw = {PEN_MOVING, PEN_DOWN, PEN_IN_HOLDER, PEN_MANUAL, FETCH_DONE,
    STOW_FAIL, DRAW_NEED, FP_SEL, FP_FORCE, FP_VALUE, CAROUSEL};

  pcu_sync #(.W($bits(pcu_pins_s))) u_sync (
    .clk(CLK),
    .nrst(NRST),
    .din(raw),
    .dout(pins)
  );

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      prev_q <= '0;
    end else begin
      prev_q <= pins;
    end
  end

  // edges of synchronised strobes
  logic sel_rise;
  logic frc_rise;
  logic done_rise;
  logic man_rise;
  logic fail_rise;
  assign sel_rise = pins.fp_sel & ~prev_q.fp_sel;
  assign frc_rise = pins.fp_force & ~prev_q.fp_force;
  assign done_rise = pins.fetch_done & ~prev_q.fetch_done;
  assign man_rise = pins.manual & ~prev_q.manual;
  assign fail_rise = pins.stow_fail & ~prev_q.stow_fail;

  // command decode
  logic cmd_wr;
  logic dflt_wr;
  logic auto_go;
  logic force_go;
  logic choose_go;
  logic signed [15:0] p0;
  logic signed [15:0] p1;
  logic auto_ok;
  logic force_bad;
  logic [3:0] force_code;
  logic choose_ok;
  logic [3:0] choose_pen;
  assign cmd = pcu_cmd_s'(WDATA[4:0]);
  assign cmd_wr = WR && (ADDR == `PCU_A_CMD);
  assign dflt_wr = WR && (ADDR == `PCU_A_DEFAULTS);
  assign auto_go = cmd_wr && (cmd.op == OP_AUTO);
  assign force_go = cmd_wr && (cmd.op == OP_FORCE);
  assign choose_go = cmd_wr && (cmd.op == OP_CHOOSE);
  assign p0 = $signed(param0_q);
  assign p1 = $signed(param1_q);
  assign auto_ok = (p0 >= 16'sh0000) && (p0 <= `PCU_AUTO_MAX);
  assign force_bad = (cmd.cnt != 3'h0) && ((p0 <= 16'sh0000) ||
    ((cmd.cnt >= 3'h2) && ((p1 <= 16'sh0000) || (p1 > `PCU_PEN_MAX))));
  assign force_code = (p0 > 16'sh0008) ? `PCU_FORCE_MAX : p0[3:0];
  assign choose_ok = (cmd.cnt == 3'h0) ||
    ((p0 >= 16'sh0000) && (p0 <= `PCU_PEN_MAX));
  assign choose_pen = (cmd.cnt == 3'h0) ? 4'h0 : p0[3:0];

  function automatic logic [3:0] car_force(input pcu_car_e c);
    if (c == CAR_DRAFT) begin
      car_force = `PCU_FORCE_DRAFT;
    end else if (c == CAR_ROLLER) begin
      car_force = `PCU_FORCE_ROLLER;
    end else begin
      car_force = `PCU_FORCE_FIBER;
    end
  endfunction

  function automatic logic [6:0] grams(input logic [3:0] c);
    case (c)
      4'h1: grams = `PCU_G1;
      4'h2: grams = `PCU_G2;
      4'h3: grams = `PCU_G3;
      4'h4: grams = `PCU_G4;
      4'h5: grams = `PCU_G5;
      4'h6: grams = `PCU_G6;
      4'h7: grams = `PCU_G7;
      4'h8: grams = `PCU_G8;
      default: grams = 7'h00;
    endcase
  endfunction

  // parameter holding registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      param0_q <= 16'h0000;
      param1_q <= 16'h0000;
    end else if (WR && (ADDR == `PCU_A_PARAM0)) begin
      param0_q <= WDATA[15:0];
    end else if (WR && (ADDR == `PCU_A_PARAM1)) begin
      param1_q <= WDATA[15:0];
    end
  end

  // automation control word
  always_ff @(posedge CLK) begin
    if (!NRST || dflt_wr) begin
      ctrl_q <= `PCU_CTRL_RST;
    end else if (auto_go) begin
      if (cmd.cnt == 3'h0) begin
        ctrl_q <= `PCU_CTRL_RST;
      end else if (auto_ok) begin
        ctrl_q <= p0[3:0];
      end
    end
  end

  // last error number
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      err_q <= `PCU_ERR_NONE;
    end else if (auto_go && (cmd.cnt != 3'h0)) begin
      if (!auto_ok) begin
        err_q <= `PCU_ERR_RANGE;
      end else if (cmd.cnt > 3'h1) begin
        err_q <= `PCU_ERR_COUNT;
      end
    end else if (force_go) begin
      if (force_bad) begin
        err_q <= `PCU_ERR_RANGE;
      end else if (cmd.cnt > 3'h2) begin
        err_q <= `PCU_ERR_COUNT;
      end
    end
  end

  // per-pen force table
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      car_q <= CAR_NONE;
      for (int i = 0; i < 8; i++) begin
        force_q[i] <= `PCU_FORCE_FIBER;
      end
    end else begin
      car_q <= pcu_car_e'(pins.car);
      if (dflt_wr || (force_go && (cmd.cnt == 3'h0))) begin
        for (int i = 0; i < 8; i++) begin
          force_q[i] <= car_force(car_q);
        end
      end else if (force_go && !force_bad) begin
        if (cmd.cnt >= 3'h2) begin
          force_q[3'(p1 - 16'sh0001)] <= force_code;
        end else begin
          for (int i = 0; i < 8; i++) begin
            force_q[i] <= force_code;
          end
        end
      end else if (frc_rise && (pins.value != 4'h0)) begin
        for (int i = 0; i < 8; i++) begin
          force_q[i] <= (pins.value > `PCU_FORCE_MAX) ? `PCU_FORCE_MAX : pins.value;
        end
      end
      if (car_force(pcu_car_e'(pins.car)) != car_force(car_q)) begin
        for (int i = 0; i < 8; i++) begin
          force_q[i] <= car_force(pcu_car_e'(pins.car));
        end
      end
    end
  end

  // pen selection and detection
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pend_q <= 1'b0;
      pend_pen_q <= 4'h0;
      FETCH_REQ <= 1'b0;
      FETCH_PEN <= 4'h0;
    end else begin
      FETCH_REQ <= 1'b0;
      if (sel_rise) begin
        FETCH_REQ <= 1'b1;
        FETCH_PEN <= pins.value;
        pend_q <= 1'b0;
      end else if (choose_go && choose_ok) begin
        if (ctrl_q[`PCU_B_DEFER] && (choose_pen != 4'h0)) begin
          pend_q <= 1'b1;
          pend_pen_q <= choose_pen;
        end else begin
          FETCH_REQ <= 1'b1;
          FETCH_PEN <= choose_pen;
          pend_q <= 1'b0;
        end
      end else if (pend_q && pins.draw_need) begin
        FETCH_REQ <= 1'b1;
        FETCH_PEN <= pend_pen_q;
        pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      known_q <= 1'b0;
      cur_pen_q <= 4'h0;
    end else if (done_rise) begin
      known_q <= 1'b1;
      cur_pen_q <= FETCH_PEN;
    end else if (man_rise) begin
      known_q <= 1'b0;
    end
  end

  // idle allotment timer
  logic active;
  logic [31:0] limit;
  assign active = known_q && pins.in_holder && (cur_pen_q != 4'h0) &&
    (ctrl_q[`PCU_B_LIFT] || ctrl_q[`PCU_B_STOW]);
  assign limit = ((car_q == CAR_TRANSP) || (car_q == CAR_DRAFT)) ?
    IDLE_SHORT_CYC : IDLE_LONG_CYC;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      st_q <= IDLE_OFF;
      cnt_q <= 32'h0;
      fire_q <= 1'b0;
    end else begin
      fire_q <= 1'b0;
      case (st_q)
        IDLE_OFF: begin
          cnt_q <= 32'h0;
          if (active && !pins.moving) begin
            st_q <= IDLE_RUN;
          end
        end
        IDLE_RUN: begin
          if (!active || pins.moving) begin
            st_q <= IDLE_OFF;
          end else if (cnt_q >= limit - 32'h1) begin
            st_q <= IDLE_DONE;
            fire_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        IDLE_DONE: begin
          if (!active || pins.moving) begin
            st_q <= IDLE_OFF;
          end
        end
        default: st_q <= IDLE_OFF;
      endcase
    end
  end

  // automatic pen actions and drawing outputs
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      LIFT_REQ <= 1'b0;
      STOW_REQ <= 1'b0;
      MERGE_EN <= 1'b0;
      FORCE_CODE <= 4'h0;
      FORCE_GRAMS <= 7'h00;
    end else begin
      LIFT_REQ <= (fire_q && ctrl_q[`PCU_B_LIFT] && pins.down) ||
        (fail_rise && ctrl_q[`PCU_B_STOW] && pins.down);
      STOW_REQ <= fire_q && ctrl_q[`PCU_B_STOW];
      MERGE_EN <= ctrl_q[`PCU_B_MERGE];
      if (cur_pen_q == 4'h0) begin
        FORCE_CODE <= 4'h0;
        FORCE_GRAMS <= 7'h00;
      end else begin
        FORCE_CODE <= force_q[3'(cur_pen_q - 4'h1)];
        FORCE_GRAMS <= grams(force_q[3'(cur_pen_q - 4'h1)]);
      end
    end
  end

  // register read port
  always_comb begin
    rdata_d = 32'h0;
    if (ADDR == `PCU_A_PARAM0) begin
      rdata_d = {16'h0, param0_q};
    end else if (ADDR == `PCU_A_PARAM1) begin
      rdata_d = {16'h0, param1_q};
    end else if (ADDR == `PCU_A_CTRL) begin
      rdata_d = {28'h0, ctrl_q};
    end else if (ADDR == `PCU_A_ERR) begin
      rdata_d = {30'h0, err_q};
    end else if (ADDR == `PCU_A_FORCES) begin
      rdata_d = {force_q[7], force_q[6], force_q[5], force_q[4],
        force_q[3], force_q[2], force_q[1], force_q[0]};
    end else if (ADDR == `PCU_A_STATUS) begin
      rdata_d = {16'h0, pend_pen_q, cur_pen_q, car_q, st_q, pend_q, known_q};
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      RDATA <= 32'h0;
    end else begin
      RDATA <= RD ? rdata_d : 32'h0;
    end
  end

  // checks
  chk_auto_default: assert property (@(posedge CLK) disable iff (!NRST)
    auto_go && cmd.cnt == 3'h0 |=> ctrl_q == `PCU_CTRL_RST)
    else $error("automation default not applied");
  chk_auto_low: assert property (@(posedge CLK) disable iff (!NRST)
    auto_go && cmd.cnt == 3'h1 && auto_ok |=> ctrl_q == $past(param0_q[3:0]))
    else $error("automation word not taken from low bits");
  chk_auto_range: assert property (@(posedge CLK) disable iff (!NRST)
    auto_go && cmd.cnt != 3'h0 && !auto_ok
    |=> ctrl_q == $past(ctrl_q) && err_q == `PCU_ERR_RANGE)
    else $error("bad automation value not dropped");
  chk_auto_extra: assert property (@(posedge CLK) disable iff (!NRST)
    auto_go && cmd.cnt > 3'h1 && auto_ok
    |=> err_q == `PCU_ERR_COUNT && ctrl_q == $past(param0_q[3:0]))
    else $error("extra automation parameter mishandled");
  chk_force_clamp: assert property (@(posedge CLK) disable iff (!NRST)
    force_go && cmd.cnt == 3'h1 && p0 > 16'sh0008 && !dflt_wr
    && car_force(pcu_car_e'(pins.car)) == car_force(car_q)
    |=> force_q[0] == `PCU_FORCE_MAX && err_q == $past(err_q))
    else $error("force not clamped");
  chk_force_bad: assert property (@(posedge CLK) disable iff (!NRST)
    force_go && force_bad |=> err_q == `PCU_ERR_RANGE)
    else $error("bad force parameter not flagged");
  chk_force_extra: assert property (@(posedge CLK) disable iff (!NRST)
    force_go && !force_bad && cmd.cnt > 3'h2 |=> err_q == `PCU_ERR_COUNT)
    else $error("extra force parameter not flagged");
  chk_defer_fetch: assert property (@(posedge CLK) disable iff (!NRST)
    choose_go && choose_ok && !sel_rise && choose_pen != 4'h0
    && ctrl_q[`PCU_B_DEFER] |=> !FETCH_REQ ##0 pend_q)
    else $error("deferred fetch issued early");
  chk_panel_fetch: assert property (@(posedge CLK) disable iff (!NRST)
    sel_rise |=> FETCH_REQ && FETCH_PEN == $past(pins.value))
    else $error("panel selection not immediate");
  chk_idle_known: assert property (@(posedge CLK) disable iff (!NRST)
    st_q == IDLE_DONE |-> $past(known_q))
    else $error("idle action on undetected pen");
  chk_merge_bit: assert property (@(posedge CLK) disable iff (!NRST)
    $changed(ctrl_q[`PCU_B_MERGE]) |=> MERGE_EN == $past(ctrl_q[`PCU_B_MERGE]))
    else $error("merge output not following bit 3");
endmodule

// ==== dv/pcu_mech_model.sv ====
// pcu_mech_model: carriage and carousel stand-in for the pen control unit
// assumes one clock, request pulses from the unit, bench picks speed and stow outcome
`timescale 1ns/1ps

module pcu_mech_model (
  input wire logic clk,
  input wire logic fetch_req,
  input wire logic [3:0] fetch_pen,
  input wire logic stow_req,
  input wire logic slow,
  input wire logic fail_stow,
  output logic moving,
  output logic fetch_done,
  output logic in_holder,
  output logic stow_fail
);
  int t;
  logic [1:0] job;

  initial begin
    moving = 1'b0;
    fetch_done = 1'b0;
    in_holder = 1'b0;
    stow_fail = 1'b0;
    t = 0;
    job = 2'h0;
  end

  // carriage travels, then reports the outcome of the job
  always @(posedge clk) begin
    fetch_done <= 1'b0;
    stow_fail <= 1'b0;
    if (fetch_req) begin
      job <= 2'h1;
      t <= slow ? 12 : 3;
      moving <= 1'b1;
    end else if (stow_req) begin
      job <= 2'h2;
      t <= slow ? 12 : 3;
      moving <= 1'b1;
    end else if (t > 1) begin
      t <= t - 1;
    end else if (t == 1) begin
      t <= 0;
      moving <= 1'b0;
      if (job == 2'h1) begin
        fetch_done <= 1'b1;
        in_holder <= (fetch_pen != 4'h0);
      end else if (fail_stow) begin
        stow_fail <= 1'b1;
      end else begin
        in_holder <= 1'b0;
      end
    end
  end
endmodule

// ==== dv/pcu_top_bench.sv ====
// pcu_top_bench: self-checking bench for the pen control command unit
// assumes shortened idle counts and the mechanism model on the far side
`timescale 1ns/1ps
`include "pcu_defs.svh"

module pcu_top_bench;
  import pcu_pkg::*;
  localparam int LONG = 40;
  localparam int SHORT = 10;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  logic PEN_DOWN = 1'b0;
  logic PEN_MANUAL = 1'b0;
  logic DRAW_NEED = 1'b0;
  logic FP_SEL = 1'b0;
  logic FP_FORCE = 1'b0;
  logic [3:0] FP_VALUE = 4'h0;
  pcu_car_e CAROUSEL = CAR_PAPER;
  logic slow = 1'b0;
  logic fail_stow = 1'b0;
  logic PEN_MOVING, FETCH_DONE, PEN_IN_HOLDER, STOW_FAIL;
  logic LIFT_REQ, STOW_REQ, FETCH_REQ, MERGE_EN;
  logic [3:0] FETCH_PEN, FORCE_CODE;
  logic [6:0] FORCE_GRAMS;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed, n;
  logic [31:0] v, d;
  logic [3:0] ectrl;
  logic [1:0] eerr;
  logic [3:0] ef [1:8];
  pcu_car_e ecar;
  pcu_car_e cars [5] = '{CAR_ROLLER, CAR_DRAFT, CAR_TRANSP, CAR_NONE, CAR_PAPER};

  pcu_top #(.IDLE_LONG_CYC(32'h28), .IDLE_SHORT_CYC(32'h0a)) pcu_top_i (.CLK(CLK), .NRST(NRST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PEN_MOVING(PEN_MOVING),
    .PEN_DOWN(PEN_DOWN), .PEN_IN_HOLDER(PEN_IN_HOLDER), .PEN_MANUAL(PEN_MANUAL),
    .FETCH_DONE(FETCH_DONE), .STOW_FAIL(STOW_FAIL), .DRAW_NEED(DRAW_NEED), .FP_SEL(FP_SEL),
    .FP_FORCE(FP_FORCE), .FP_VALUE(FP_VALUE), .CAROUSEL(CAROUSEL), .LIFT_REQ(LIFT_REQ),
    .STOW_REQ(STOW_REQ), .FETCH_REQ(FETCH_REQ), .FETCH_PEN(FETCH_PEN), .MERGE_EN(MERGE_EN),
    .FORCE_CODE(FORCE_CODE), .FORCE_GRAMS(FORCE_GRAMS));

  pcu_mech_model pcu_mech_model_i (.clk(CLK), .fetch_req(FETCH_REQ), .fetch_pen(FETCH_PEN),
    .stow_req(STOW_REQ), .slow(slow), .fail_stow(fail_stow), .moving(PEN_MOVING),
    .fetch_done(FETCH_DONE), .in_holder(PEN_IN_HOLDER), .stow_fail(STOW_FAIL));

  initial begin
    forever #25 CLK = ~CLK;
  end

  task automatic final_report();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  function automatic logic [3:0] defc(input pcu_car_e c);
    return (c == CAR_DRAFT) ? 4'h1 : (c == CAR_ROLLER) ? 4'h6 : 4'h2;
  endfunction

  function automatic logic [6:0] grams(input logic [3:0] c);
    logic [6:0] g [1:8] = '{7'h0f, 7'h18, 7'h1e, 7'h24, 7'h2d, 7'h33, 7'h39, 7'h42};
    return g[c];
  endfunction

  function automatic logic [31:0] fword();
    logic [31:0] w;
    for (int i = 1; i <= 8; i++) w[4*i-1 -: 4] = ef[i];
    return w;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= dat;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    dat = RDATA;
  endtask

  task automatic cmd(input pcu_op_e op, input logic [2:0] cnt, input logic [15:0] p0, p1);
    wr(`PCU_A_PARAM0, {16'h0000, p0});
    wr(`PCU_A_PARAM1, {16'h0000, p1});
    wr(`PCU_A_CMD, {27'h0, cnt, op});
  endtask

  task automatic chk_regs();
    logic [31:0] r;
    rd(`PCU_A_CTRL, r);
    chk(r, {28'h0, ectrl});
    rd(`PCU_A_ERR, r);
    chk(r, {30'h0, eerr});
    rd(`PCU_A_FORCES, r);
    chk(r, fword());
    chk({31'h0, MERGE_EN}, {31'h0, ectrl[3]});
  endtask

  task automatic auto(input logic [2:0] cnt, input logic [15:0] p);
    cmd(OP_AUTO, cnt, p, 16'h0000);
    if (cnt == 3'h0) ectrl = 4'h7;
    else if ($signed(p) < 0 || $signed(p) > 15) eerr = 2'h3;
    else begin
      ectrl = p[3:0];
      if (cnt > 3'h1) eerr = 2'h2;
    end
    chk_regs();
  endtask

  task automatic force_cmd(input logic [2:0] cnt, input logic [15:0] p0, p1);
    logic [3:0] c;
    cmd(OP_FORCE, cnt, p0, p1);
    c = ($signed(p0) > 8) ? 4'h8 : p0[3:0];
    if (cnt == 3'h0) for (int i = 1; i <= 8; i++) ef[i] = defc(ecar);
    else if ($signed(p0) <= 0 || (cnt > 3'h1 && ($signed(p1) <= 0 || $signed(p1) > 8)))
      eerr = 2'h3;
    else begin
      if (cnt > 3'h1) ef[p1] = c;
      else for (int i = 1; i <= 8; i++) ef[i] = c;
      if (cnt > 3'h2) eerr = 2'h2;
    end
    chk_regs();
  endtask

  task automatic setcar(input pcu_car_e c);
    @(posedge CLK);
    CAROUSEL <= c;
    if (defc(c) != defc(ecar)) for (int i = 1; i <= 8; i++) ef[i] = defc(c);
    ecar = c;
    repeat (6) @(posedge CLK);
  endtask

  function automatic bit seen(input int w);
    return (w == 0 && LIFT_REQ === 1'b1) || (w == 1 && STOW_REQ === 1'b1) ||
      (w == 2 && FETCH_REQ === 1'b1) || (w == 3 && FETCH_DONE === 1'b1);
  endfunction

  // looks at the current cycle first: request pulses stand one cycle only
  task automatic wait_out(input int w, input int lim, output int cnt);
    cnt = 0;
    #1;
    while (cnt < lim && !seen(w)) begin
      @(posedge CLK);
      #1;
      cnt++;
    end
  endtask

  task automatic fetch_pen(input logic [15:0] p);
    int k;
    cmd(OP_CHOOSE, 3'h1, p, 16'h0000);
    wait_out(2, 10, k);
    chk({31'h0, k < 10}, 32'h1);
    wait_out(3, 20, k);
  endtask

  initial begin
    seed = 32'hbbb5;
    repeat (8) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    #1;
    chk({29'h0, LIFT_REQ, STOW_REQ, FETCH_REQ}, 32'h0);
    ectrl = 4'h7;
    eerr = 2'h0;
    ecar = CAR_PAPER;
    for (int i = 1; i <= 8; i++) ef[i] = 4'h2;
    repeat (4) @(posedge CLK);
    chk_regs();
    auto(3'h1, 16'h0000);
    auto(3'h0, 16'h0009);
    auto(3'h2, 16'h0005);
    auto(3'h1, 16'h0010);
    auto(3'h1, 16'hffff);
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      auto(v[0] ? 3'h2 : 3'h1, {11'h0, v[8:4]});
    end
    auto(3'h1, 16'h0000);
    fetch_pen(16'h0003);
    for (int c = 1; c <= 9; c++) begin
      force_cmd(3'h2, 16'(c), 16'h0003);
      chk({28'h0, FORCE_CODE}, (c > 8) ? 32'h8 : 32'(c));
      chk({25'h0, FORCE_GRAMS}, {25'h0, grams(ef[3])});
    end
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      force_cmd(v[0] ? 3'h1 : 3'h2, {12'h0, v[7:4]}, {12'h0, v[11:8]});
    end
    force_cmd(3'h3, 16'h0005, 16'h0002);
    force_cmd(3'h2, 16'h0000, 16'h0001);
    force_cmd(3'h2, 16'h0003, 16'h0009);
    force_cmd(3'h1, 16'hfffe, 16'h0000);
    @(posedge CLK);
    FP_VALUE <= 4'h4;
    FP_FORCE <= 1'b1;
    repeat (6) @(posedge CLK);
    FP_FORCE <= 1'b0;
    for (int i = 1; i <= 8; i++) ef[i] = 4'h4;
    chk_regs();
    foreach (cars[i]) begin
      setcar(cars[i]);
      chk_regs();
      force_cmd(3'h1, 16'h0003, 16'h0000);
      force_cmd(3'h0, 16'h0000, 16'h0000);
    end
    auto(3'h1, 16'h0004);
    cmd(OP_CHOOSE, 3'h1, 16'h0005, 16'h0000);
    wait_out(2, 12, n);
    chk(n, 32'd12);
    DRAW_NEED <= 1'b1;
    wait_out(2, 10, n);
    chk({31'h0, n < 10}, 32'h1);
    chk({28'h0, FETCH_PEN}, 32'h5);
    DRAW_NEED <= 1'b0;
    wait_out(3, 20, n);
    FP_VALUE <= 4'h6;
    FP_SEL <= 1'b1;
    wait_out(2, 10, n);
    chk({31'h0, n < 10}, 32'h1);
    chk({28'h0, FETCH_PEN}, 32'h6);
    FP_SEL <= 1'b0;
    wait_out(3, 20, n);
    auto(3'h1, 16'h0003);
    PEN_DOWN <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      setcar(k[0] ? CAR_TRANSP : CAR_PAPER);
      fetch_pen(16'h0002);
      wait_out(0, 80, n);
      d = k[0] ? SHORT : LONG;
      chk({31'h0, n >= d && n <= d + 10}, 32'h1);
      chk({31'h0, STOW_REQ}, 32'h1);
    end
    auto(3'h1, 16'h0002);
    fail_stow <= 1'b1;
    fetch_pen(16'h0004);
    wait_out(1, 80, n);
    chk({31'h0, n < 80}, 32'h1);
    wait_out(0, 30, n);
    chk({31'h0, n < 30}, 32'h1);
    fail_stow <= 1'b0;
    auto(3'h1, 16'h0001);
    fetch_pen(16'h0001);
    // let the fetch detection settle before the hand insertion
    repeat (4) @(posedge CLK);
    PEN_MANUAL <= 1'b1;
    repeat (2) @(posedge CLK);
    PEN_MANUAL <= 1'b0;
    wait_out(0, 80, n);
    chk(n, 32'd80);
    wr(`PCU_A_DEFAULTS, 32'h0);
    ectrl = 4'h7;
    for (int i = 1; i <= 8; i++) ef[i] = defc(ecar);
    chk_regs();
    rd(8'hf0, d);
    chk(d, 32'h0);
    final_report();
  end
endmodule
